// ===== rtl/mapped_bidir_io_pkg.sv
package mapped_bidir_io_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] SPECIAL_FUNCTION_SPACE_LO = 16'h0000;
  localparam logic [15:0] SPECIAL_FUNCTION_SPACE_HI = 16'h003F;
  localparam logic [15:0] DATA_BUFFER_SPACE_LO = 16'h0F80;
  localparam logic [15:0] DATA_BUFFER_SPACE_HI = 16'h0FFF;
  localparam logic [15:0] PORT_OUTPUT_LATCH_ADDR = 16'h0000;
  localparam logic [15:0] PORT_DIRECTION_CONTROL_ADDR = 16'h0008;
  localparam logic [7:0] PORT_OUTPUT_LATCH_RST = 8'h00;
  localparam logic [7:0] PORT_DIRECTION_CONTROL_RST = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_S1 = 2'b01,
    PH_S2 = 2'b11
  } bus_phase_t;
endpackage

// ===== rtl/mapped_bidir_io_port.sv
// Operation
// - Decode special-function space 0000H..003FH as ordinary memory accesses.
// - Decode data-buffer space 0F80H..0FFFH as ordinary memory accesses.
// - Accesses to non-accessible locations get no register behaviour.
// - Each output bit keeps a latch holding last written value, driven out.
// - Pin levels are sampled in S1 of the read cycle.
// - Pin output data changes in S2 of the write cycle.
// - Eight pins, each direction set by its direction control bit.
// - Reset clears direction control, all pins inputs.
// - Reset clears all output latch bits.
// - Input-mode bits read pin level, so read-modify-write copies pins into latch.
`timescale 1ns/1ps
`default_nettype none
module mapped_bidir_io_port (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata,
  output logic spaceHit,
  input wire logic [7:0] portPinsIn,
  output logic [7:0] portPinsOut,
  output logic [7:0] portPinsOe
);
  // Access lasts two cycles: S1 (capture) then S2 (complete)
  mapped_bidir_io_pkg::bus_phase_t phase_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic isWrite_q;
  logic [7:0] pinMeta_q;
  logic [7:0] pinSync_q;
  logic [7:0] portOutputLatch_q;
  logic [7:0] portDirectionControl_q;
  logic inSfr;
  logic inDbr;
  logic [7:0] mixedRead;

  assign inSfr = memAddr <= mapped_bidir_io_pkg::SPECIAL_FUNCTION_SPACE_HI;
  assign inDbr = (memAddr >= mapped_bidir_io_pkg::DATA_BUFFER_SPACE_LO) &&
                 (memAddr <= mapped_bidir_io_pkg::DATA_BUFFER_SPACE_HI);

  // Pins are asynchronous to the core, two flops before use
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_q <= 8'h00;
      pinSync_q <= 8'h00;
    end else begin
      pinMeta_q <= portPinsIn;
      pinSync_q <= pinMeta_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= mapped_bidir_io_pkg::PH_IDLE;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      isWrite_q <= 1'b0;
    end else begin
      case (phase_q)
        mapped_bidir_io_pkg::PH_IDLE: begin
          if (memRead || memWrite) begin
            phase_q <= mapped_bidir_io_pkg::PH_S1;
            addr_q <= memAddr;
            wdata_q <= memWdata;
            isWrite_q <= memWrite;
          end
        end
        mapped_bidir_io_pkg::PH_S1: phase_q <= mapped_bidir_io_pkg::PH_S2;
        mapped_bidir_io_pkg::PH_S2: phase_q <= mapped_bidir_io_pkg::PH_IDLE;
        default: phase_q <= mapped_bidir_io_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      spaceHit <= 1'b0;
    end else if ((phase_q == mapped_bidir_io_pkg::PH_IDLE) && (memRead || memWrite)) begin
      spaceHit <= inSfr || inDbr;
    end else if (phase_q == mapped_bidir_io_pkg::PH_S2) begin
      spaceHit <= 1'b0;
    end
  end

  // Input bits show the pin, output bits show the latch
  assign mixedRead = (pinSync_q & ~portDirectionControl_q) |
                     (portOutputLatch_q & portDirectionControl_q);

  // Pin data sampled in S1; unmapped or other addresses read zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      memRdata <= mapped_bidir_io_pkg::READ_IDLE_VALUE;
    end else if ((phase_q == mapped_bidir_io_pkg::PH_S1) && !isWrite_q) begin
      case (addr_q)
        mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_ADDR: memRdata <= mixedRead;
        mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_ADDR: memRdata <= portDirectionControl_q;
        default: memRdata <= mapped_bidir_io_pkg::READ_IDLE_VALUE;
      endcase
    end
  end

  // Writes take effect in S2
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      portOutputLatch_q <= mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_RST;
      portDirectionControl_q <= mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_RST;
    end else if ((phase_q == mapped_bidir_io_pkg::PH_S2) && isWrite_q) begin
      if (addr_q == mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_ADDR) begin
        portOutputLatch_q <= wdata_q;
      end
      if (addr_q == mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_ADDR) begin
        portDirectionControl_q <= wdata_q;
      end
    end
  end

  // Pin copies load with the latch itself, so the pins move on the edge ending S2
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      portPinsOut <= mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_RST;
      portPinsOe <= mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_RST;
    end else if ((phase_q == mapped_bidir_io_pkg::PH_S2) && isWrite_q) begin
      if (addr_q == mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_ADDR) begin
        portPinsOut <= wdata_q;
      end
      if (addr_q == mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_ADDR) begin
        portPinsOe <= wdata_q;
      end
    end
  end

  AST_RESET_INPUTS: assert property (@(posedge core_clk)
    $rose(reset_n) |-> portPinsOe == 8'h00)
    else $error("Pins not inputs after reset");
  AST_LATCH_RESET: assert property (@(posedge core_clk)
    $rose(reset_n) |-> portOutputLatch_q == 8'h00)
    else $error("Latch not cleared at reset");
  AST_WRITE_LATCH: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_S2 && isWrite_q &&
     addr_q == mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_ADDR) |=> portPinsOut == $past(wdata_q))
    else $error("Pin data not updated after write");
  AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(phase_q == mapped_bidir_io_pkg::PH_S2 && isWrite_q) |=> $stable(portOutputLatch_q))
    else $error("Latch changed without write");
  AST_DIR_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_S2 && isWrite_q &&
     addr_q == mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_ADDR) |=> portPinsOe == $past(wdata_q))
    else $error("Direction not applied");
  AST_OE_FOLLOWS: assert property (@(posedge core_clk) disable iff (!reset_n)
    portPinsOe == portDirectionControl_q)
    else $error("Enable does not follow direction");
  AST_READ_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_S1 && !isWrite_q &&
     addr_q == mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_ADDR) |=>
     memRdata == (($past(pinSync_q) & ~$past(portDirectionControl_q)) |
                  ($past(portOutputLatch_q) & $past(portDirectionControl_q))))
    else $error("Port read wrong");
  AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_S1 && !isWrite_q &&
     addr_q != mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_ADDR &&
     addr_q != mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_ADDR) |=>
     memRdata == mapped_bidir_io_pkg::READ_IDLE_VALUE)
    else $error("Unmapped read not zero");
  AST_SPACE_HIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_IDLE && (memRead || memWrite) &&
     memAddr >= mapped_bidir_io_pkg::DATA_BUFFER_SPACE_LO &&
     memAddr <= mapped_bidir_io_pkg::DATA_BUFFER_SPACE_HI) |=> spaceHit)
    else $error("Data buffer space not decoded");

  // Decode flag: set at the take edge, held through S1, dropped after S2
  AST_SFR_HIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_IDLE && (memRead || memWrite) &&
     memAddr <= mapped_bidir_io_pkg::SPECIAL_FUNCTION_SPACE_HI) |=> spaceHit)
    else $error("Special function space not decoded");
  AST_OUTSIDE_MISS: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_IDLE && (memRead || memWrite) &&
     memAddr > mapped_bidir_io_pkg::SPECIAL_FUNCTION_SPACE_HI &&
     (memAddr < mapped_bidir_io_pkg::DATA_BUFFER_SPACE_LO ||
      memAddr > mapped_bidir_io_pkg::DATA_BUFFER_SPACE_HI)) |=> !spaceHit)
    else $error("Address outside both spaces flagged as hit");
  AST_HIT_DROPS: assert property (@(posedge core_clk) disable iff (!reset_n)
    phase_q == mapped_bidir_io_pkg::PH_S2 |=> !spaceHit)
    else $error("Hit flag not dropped after access");
  AST_HIT_STANDS: assert property (@(posedge core_clk) disable iff (!reset_n)
    phase_q == mapped_bidir_io_pkg::PH_S1 |=> $stable(spaceHit))
    else $error("Hit flag changed inside access");

  // Access sequencing: requests in flight are ignored until the phase returns to idle
  AST_PHASE_S1_TO_S2: assert property (@(posedge core_clk) disable iff (!reset_n)
    phase_q == mapped_bidir_io_pkg::PH_S1 |=> phase_q == mapped_bidir_io_pkg::PH_S2)
    else $error("S1 not followed by S2");
  AST_PHASE_S2_TO_IDLE: assert property (@(posedge core_clk) disable iff (!reset_n)
    phase_q == mapped_bidir_io_pkg::PH_S2 |=> phase_q == mapped_bidir_io_pkg::PH_IDLE)
    else $error("S2 not followed by idle");
  AST_TAKE_WRITE_WINS: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_IDLE && memWrite) |=> (phase_q == mapped_bidir_io_pkg::PH_S1 && isWrite_q))
    else $error("Write request not taken as write");
  AST_BUSY_IGNORES: assert property (@(posedge core_clk) disable iff (!reset_n)
    phase_q != mapped_bidir_io_pkg::PH_IDLE |=> $stable(addr_q))
    else $error("Address recaptured during access");

  // Register contents move only on their own write; reads leave everything alone
  AST_DIR_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(phase_q == mapped_bidir_io_pkg::PH_S2 && isWrite_q &&
      addr_q == mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_ADDR) |=> $stable(portDirectionControl_q))
    else $error("Direction changed without write");
  AST_READ_DIR: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_S1 && !isWrite_q &&
     addr_q == mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_ADDR) |=> memRdata == $past(portDirectionControl_q))
    else $error("Direction read back wrong");
  AST_RDATA_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(phase_q == mapped_bidir_io_pkg::PH_S1 && !isWrite_q) |=> $stable(memRdata))
    else $error("Read data changed outside S1");
  AST_UNMAPPED_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_S2 && isWrite_q &&
     addr_q != mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_ADDR &&
     addr_q != mapped_bidir_io_pkg::PORT_DIRECTION_CONTROL_ADDR) |=>
     ($stable(portOutputLatch_q) && $stable(portDirectionControl_q)))
    else $error("Unmapped write changed a register");
  AST_INPUT_BITS_READ: assert property (@(posedge core_clk) disable iff (!reset_n)
    (phase_q == mapped_bidir_io_pkg::PH_S1 && !isWrite_q &&
     addr_q == mapped_bidir_io_pkg::PORT_OUTPUT_LATCH_ADDR) |=>
     ((memRdata ^ $past(pinSync_q)) & ~$past(portDirectionControl_q)) == 8'h00)
    else $error("Input bit did not read pin level");

  // Pin copies must never drift from the latch they mirror
  AST_PINS_MATCH_LATCH: assert property (@(posedge core_clk) disable iff (!reset_n)
    portPinsOut == portOutputLatch_q)
    else $error("Pin drive differs from latch");
  AST_RESET_PINS_LOW: assert property (@(posedge core_clk)
    $rose(reset_n) |-> portPinsOut == 8'h00)
    else $error("Pin drive not cleared at reset");
endmodule
`default_nettype wire

// ===== dv/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic [7:0] extDrive,
  input wire logic [7:0] portPinsOut,
  input wire logic [7:0] portPinsOe,
  output logic [7:0] pinLevel
);
  // Driven bits follow the port; the rest follow the outside source directly, with no holding
  assign pinLevel = (portPinsOe & portPinsOut) | (~portPinsOe & extDrive);
endmodule
`default_nettype wire

// ===== dv/tb_mapped_bidir_io_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mapped_bidir_io_port;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] memAddr = 16'h0000;
  logic memRead = 1'b0;
  logic memWrite = 1'b0;
  logic [7:0] memWdata = 8'h00;
  logic [7:0] extDrive = 8'h00;
  logic [7:0] memRdata, portPinsOut, portPinsOe, pinLevel, dir, lat;
  logic spaceHit;
  logic took = 1'b0;
  logic [8:0] expQ[$];
  logic [15:0] adr [6] = '{16'h003F, 16'h0040, 16'h0F7F, 16'h0F90, 16'h0FB0, 16'h1000};
  logic [5:0] hitMask = 6'b011001;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 32'h3eff;
  always #2 core_clk = ~core_clk;
  mapped_bidir_io_port dut (.core_clk(core_clk), .reset_n(reset_n), .memAddr(memAddr),
    .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata),
    .spaceHit(spaceHit), .portPinsIn(pinLevel), .portPinsOut(portPinsOut),
    .portPinsOe(portPinsOe));
  pin_partner far (.extDrive(extDrive), .portPinsOut(portPinsOut), .portPinsOe(portPinsOe),
    .pinLevel(pinLevel));
  task automatic chk(input string nm, input logic [8:0] ex, input logic [8:0] got);
    samples_checked++;
    if (got !== ex) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One request per access, held for the take edge only, then a quiet gap
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 memAddr = a;
    memWdata = d;
    memWrite = wr;
    memRead = !wr;
    @(posedge core_clk);
    #1 memRead = 1'b0;
    memWrite = 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [8:0] ex);
    expQ.push_back(ex);
    access(1'b0, a, 8'h00);
  endtask
  task automatic print_verdict();
    if (expQ.size() != 0) n_fail++;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) took <= memRead & !memWrite;
  // Read data and hit flag are settled one edge after the take edge
  always @(posedge core_clk) begin
    if (took) begin
      #1 chk("read", expQ.pop_front(), {spaceHit, memRdata});
    end
  end
  initial begin
    #20000 n_fail++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset_n = 1'b1;
    chk("oe", 9'h000, {1'b0, portPinsOe});
    chk("out", 9'h000, {1'b0, portPinsOut});
    extDrive = 8'h5A;
    repeat (3) @(posedge core_clk);
    rd(16'h0008, 9'h100);
    rd(16'h0000, {1'b1, 8'h5A});
    for (int i = 0; i < 6; i++) begin
      dir = 8'($random(seed));
      lat = 8'($random(seed));
      access(1'b1, 16'h0008, dir);
      access(1'b1, 16'h0000, lat);
      #1 extDrive = 8'($random(seed));
      repeat (3) @(posedge core_clk);
      #1 chk("oe", {1'b0, dir}, {1'b0, portPinsOe});
      chk("out", {1'b0, lat}, {1'b0, portPinsOut});
      rd(16'h0000, {1'b1, (lat & dir) | (extDrive & ~dir)});
      rd(16'h0008, {1'b1, dir});
    end
    access(1'b1, 16'h0010, 8'hFF);
    access(1'b1, 16'h0F90, 8'hFF);
    access(1'b1, 16'h0040, 8'hFF);
    rd(16'h0008, {1'b1, dir});
    rd(16'h0000, {1'b1, (lat & dir) | (extDrive & ~dir)});
    for (int i = 0; i < 6; i++) rd(adr[i], {hitMask[i], 8'h00});
    // Mid-run reset with non-zero direction and latch
    #1 reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    chk("oe", 9'h000, {1'b0, portPinsOe});
    chk("out", 9'h000, {1'b0, portPinsOut});
    repeat (3) @(posedge core_clk);
    rd(16'h0008, 9'h100);
    rd(16'h0000, {1'b1, extDrive});
    repeat (4) @(posedge core_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
